// File: logic/serial_port_pkg.sv
// Shared constants and types for the synthesizer serial programming port.
package serial_port_pkg;
   // Frame layout: one direction flag, seven address bits, sixteen data bits.
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int FRAME_W = 1 + ADDR_W + DATA_W;
   localparam int DEPTH = 128;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] ADDR_END = 5'h08;
   localparam logic [CNT_W-1:0] FRAME_END = 5'h18;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
   typedef enum logic {ST_IDLE, ST_FRAME} frame_state_t;
endpackage : serial_port_pkg

// File: logic/config_store_if.sv
// Interface joining the serial port to its configuration store.
`timescale 1ns/1ps
`default_nettype none
interface config_store_if;
   logic wr_en;
   logic [serial_port_pkg::ADDR_W-1:0] wr_addr;
   logic [serial_port_pkg::DATA_W-1:0] wr_data;
   logic [serial_port_pkg::ADDR_W-1:0] rd_addr;
   logic [serial_port_pkg::DATA_W-1:0] rd_data;
   modport port (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : config_store_if
`default_nettype wire

// File: logic/config_store.sv
// Register-read memory that keeps the configuration words.
`timescale 1ns/1ps
`default_nettype none
module config_store
(
   input wire logic clk_sys_in,
   config_store_if.store bus
);
   logic [serial_port_pkg::DATA_W-1:0] mem [serial_port_pkg::DEPTH];

   // Writes land on the clock edge; the read word is registered.
   always_ff @(posedge clk_sys_in)
   begin
      if (bus.wr_en)
      begin
         mem[bus.wr_addr] <= bus.wr_data;
      end
      bus.rd_data <= mem[bus.rd_addr];
   end
endmodule : config_store
`default_nettype wire

// File: logic/synth_serial_program_port.sv
// Serial programming port: frames writes into the store and shifts readback out.
`timescale 1ns/1ps
`default_nettype none
module synth_serial_program_port
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic select_low_pin_in,
   input wire logic serial_clock_pin_in,
   input wire logic serial_in_pin_in,
   output logic multiplexed_out_pin_out
);
   config_store_if store_bus ();

   config_store u_store
   (
      .clk_sys_in(clk_sys_in),
      .bus(store_bus.store)
   );

   // Two-stage synchronisers; the first stage feeds only the second.
   logic [1:0] sel_sync;
   logic [1:0] sck_sync;
   logic [1:0] sdi_sync;
   logic sck_prev;
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         sel_sync <= 2'h3;
         sck_sync <= 2'h0;
         sdi_sync <= 2'h0;
         sck_prev <= 1'b0;
      end
      else
      begin
         sel_sync <= {sel_sync[0], select_low_pin_in};
         sck_sync <= {sck_sync[0], serial_clock_pin_in};
         sdi_sync <= {sdi_sync[0], serial_in_pin_in};
         sck_prev <= sck_sync[1];
      end
   end

   logic selected;
   logic sck_rise;
   logic sck_fall;
   assign selected = ~sel_sync[1];
   // Edges only count while selected, so a free clock with select high does nothing.
   assign sck_rise = selected & sck_sync[1] & ~sck_prev;
   assign sck_fall = selected & ~sck_sync[1] & sck_prev;

   serial_port_pkg::frame_state_t state;
   logic [serial_port_pkg::CNT_W-1:0] bit_cnt;
   logic [serial_port_pkg::FRAME_W-2:0] shift;
   logic dir;
   logic [serial_port_pkg::DATA_W-1:0] rd_shift;

   // Frame state follows select; a deselect mid-frame abandons the frame.
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         state <= serial_port_pkg::ST_IDLE;
      end
      else
      begin
         unique case (state)
            serial_port_pkg::ST_IDLE:
            begin
               if (selected)
               begin
                  state <= serial_port_pkg::ST_FRAME;
               end
            end
            serial_port_pkg::ST_FRAME:
            begin
               if (!selected)
               begin
                  state <= serial_port_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Bit counter and input shift register, sampled on rising serial clock.
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || !selected)
      begin
         bit_cnt <= '0;
         shift <= '0;
         dir <= serial_port_pkg::DIR_WRITE;
      end
      else if (sck_rise && bit_cnt != serial_port_pkg::FRAME_END)
      begin
         bit_cnt <= bit_cnt + 1'b1;
         if (bit_cnt == '0)
         begin
            dir <= sdi_sync[1];
         end
         else if (!(dir == serial_port_pkg::DIR_READ && bit_cnt >= serial_port_pkg::ADDR_END))
         begin
            shift <= {shift[serial_port_pkg::FRAME_W-3:0], sdi_sync[1]};
         end
      end
   end

   // A write commits once all bits are in; partial frames never commit.
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         store_bus.wr_en <= 1'b0;
         store_bus.wr_addr <= '0;
         store_bus.wr_data <= serial_port_pkg::REG_RESET;
      end
      else
      begin
         store_bus.wr_en <= sck_rise && dir == serial_port_pkg::DIR_WRITE
            && bit_cnt == serial_port_pkg::FRAME_END - 1'b1;
         store_bus.wr_addr <= shift[serial_port_pkg::FRAME_W-3 -: serial_port_pkg::ADDR_W];
         store_bus.wr_data <= {shift[serial_port_pkg::DATA_W-2:0], sdi_sync[1]};
      end
   end

   // Read address is the shifted address once the address phase is complete.
   assign store_bus.rd_addr = shift[serial_port_pkg::ADDR_W-1:0];

   // Readback shifter: loaded at the last address bit, advanced on falling clock.
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || !selected)
      begin
         rd_shift <= '0;
         multiplexed_out_pin_out <= 1'b0;
      end
      else if (dir == serial_port_pkg::DIR_READ && bit_cnt >= serial_port_pkg::ADDR_END)
      begin
         if (sck_fall)
         begin
            if (bit_cnt == serial_port_pkg::ADDR_END)
            begin
               // The memory word has had several cycles to settle by this fall.
               multiplexed_out_pin_out <= store_bus.rd_data[serial_port_pkg::DATA_W-1];
               rd_shift <= {store_bus.rd_data[serial_port_pkg::DATA_W-2:0], 1'b0};
            end
            else
            begin
               multiplexed_out_pin_out <= rd_shift[serial_port_pkg::DATA_W-1];
               rd_shift <= {rd_shift[serial_port_pkg::DATA_W-2:0], 1'b0};
            end
         end
      end
      else
      begin
         multiplexed_out_pin_out <= 1'b0;
      end
   end

   // Output stays low while the address is still arriving.
   property p_addr_low;
      @(posedge clk_sys_in) disable iff (rst_in)
      (bit_cnt < serial_port_pkg::ADDR_END) |=> !multiplexed_out_pin_out;
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("output high in address phase");

   // Deselected: counter cleared and edges ignored.
   property p_desel;
      @(posedge clk_sys_in) disable iff (rst_in)
      !selected |=> (bit_cnt == '0) && !store_bus.wr_en;
   endproperty
   a_desel: assert property (p_desel) else $error("activity while deselected");

   // Each selected rising edge below the last frame bit advances the counter by one.
   property p_count;
      @(posedge clk_sys_in) disable iff (rst_in)
      (sck_rise && selected && bit_cnt < serial_port_pkg::FRAME_END - 1'b1) ##1 selected
      |-> bit_cnt == $past(bit_cnt) + 1'b1;
   endproperty
   a_count: assert property (p_count) else $error("bit counter did not advance");

   // Writes only for write frames at the last bit.
   property p_write;
      @(posedge clk_sys_in) disable iff (rst_in)
      store_bus.wr_en |-> $past(dir) == serial_port_pkg::DIR_WRITE
         && $past(bit_cnt) == serial_port_pkg::FRAME_END - 1'b1;
   endproperty
   a_write: assert property (p_write) else $error("write outside full write frame");

   // Readback output moves only after a falling clock.
   property p_change_on_fall;
      @(posedge clk_sys_in) disable iff (rst_in)
      (selected && $changed(multiplexed_out_pin_out)) |-> $past(sck_fall);
   endproperty
   a_change_on_fall: assert property (p_change_on_fall) else $error("readback moved off fall");

   // Input is not shifted during readback data.
   property p_ignore_in;
      @(posedge clk_sys_in) disable iff (rst_in)
      (selected && dir == serial_port_pkg::DIR_READ && bit_cnt >= serial_port_pkg::ADDR_END)
      ##1 selected |-> $stable(shift);
   endproperty
   a_ignore_in: assert property (p_ignore_in) else $error("input taken in readback data");

   // Out of a frame the output rests low, whatever the store happens to hold.
   property p_idle_out;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state == serial_port_pkg::ST_IDLE) |-> !multiplexed_out_pin_out;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("output high outside a frame");
endmodule : synth_serial_program_port
`default_nettype wire

// File: test/host_model.sv
// Host controller model that frames transfers on the serial programming pins.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   input wire logic clk_sys_in,
   input wire logic miso_in,
   output logic select_low_pin_out,
   output logic serial_clock_pin_out,
   output logic serial_in_pin_out
);
   int low_errors;
   // Idle lines: select high, clock parked low so select may fall at any time.
   initial
   begin
      low_errors = 0;
      select_low_pin_out = 1'b1;
      serial_clock_pin_out = 1'b0;
      serial_in_pin_out = 1'b0;
   end
   // One frame of n bits; with sel low the select line is never lowered.
   task automatic frame(input logic [23:0] w, input int n, input logic sel,
      output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk_sys_in);
      select_low_pin_out <= ~sel;
      for (int i = 0; i < n; i++)
      begin
         // Read data bits carry a toggling pattern that must not matter.
         serial_in_pin_out <= (w[23] && i > 7) ? i[0] : w[23 - i];
         repeat (4) @(posedge clk_sys_in);
         serial_clock_pin_out <= 1'b1;
         repeat (2) @(negedge clk_sys_in);
         if (i > 7)
            rd = {rd[14:0], miso_in};
         else if (w[23] && sel && miso_in !== 1'b0)
            low_errors++;
         repeat (3) @(posedge clk_sys_in);
         serial_clock_pin_out <= 1'b0;
      end
      repeat (4) @(posedge clk_sys_in);
      select_low_pin_out <= 1'b1;
      // Released data line shows the inverse so a stale level is never trusted.
      serial_in_pin_out <= ~serial_in_pin_out;
      repeat (4) @(posedge clk_sys_in);
   endtask : frame
endmodule : host_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking testbench for the serial programming port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic select_low_pin_in;
   logic serial_clock_pin_in;
   logic serial_in_pin_in;
   logic multiplexed_out_pin_out;
   logic [15:0] rd;
   int miscompares = 0;
   int tests_run = 0;
   // Free-running 20 MHz system clock.
   always #25 clk_sys_in = ~clk_sys_in;
   synth_serial_program_port u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .select_low_pin_in(select_low_pin_in), .serial_clock_pin_in(serial_clock_pin_in),
      .serial_in_pin_in(serial_in_pin_in), .multiplexed_out_pin_out(multiplexed_out_pin_out));
   host_model u_host (.clk_sys_in(clk_sys_in), .miso_in(multiplexed_out_pin_out),
      .select_low_pin_out(select_low_pin_in), .serial_clock_pin_out(serial_clock_pin_in),
      .serial_in_pin_out(serial_in_pin_in));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // Back-to-back writes at the two end addresses and 7'h2a, then read each one back.
   task automatic write_read();
      logic [6:0] a[3] = '{7'h00, 7'h7f, 7'h2a};
      logic [15:0] d[3] = '{16'h8001, 16'ha53c, 16'h7ffe};
      for (int i = 0; i < 3; i++)
         u_host.frame({1'b0, a[i], d[i]}, 24, 1'b1, rd);
      for (int i = 0; i < 3; i++)
      begin
         u_host.frame({1'b1, a[i], 16'h0000}, 24, 1'b1, rd);
         check(rd, d[i]);
      end
   endtask : write_read
   // Clock pulses with select high and an abandoned frame leave the word alone.
   task automatic refused_frames();
      u_host.frame({1'b0, 7'h2a, 16'h1234}, 24, 1'b0, rd);
      u_host.frame({1'b1, 7'h2a, 16'h0000}, 24, 1'b1, rd);
      check(rd, 16'h7ffe);
      u_host.frame({1'b0, 7'h2a, 16'h5555}, 12, 1'b1, rd);
      u_host.frame({1'b1, 7'h2a, 16'h0000}, 24, 1'b1, rd);
      check(rd, 16'h7ffe);
      check(16'(u_host.low_errors), 16'h0000);
   endtask : refused_frames
   // Main sequence: synchronous reset for 12 cycles, then the scenarios.
   initial
   begin
      repeat (12) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      write_read();
      refused_frames();
      finish_test();
   end
   // Watchdog cuts a hang short and counts it as a mismatch.
   initial
   begin
      repeat (100000) @(posedge clk_sys_in);
      miscompares++;
      finish_test();
   end
endmodule : testbench
`default_nettype wire
